/* pkg/rtc_pkg.sv */
// Purpose: shared constants and types for the match counter and its controller
// Assumes: one 100 MHz clock; config mux runs on that same clock
// Notes: control byte fields, link byte map and host state codes
// Function
// - 40-bit user-loadable up-counter
// - divide timebase by 128, then count
// - timebase comes from crystal oscillator output
// - counter written and read at same addresses
// - count reads come from a read-hold copy
// - match bits all ones on equality
// - both match outputs high on equality only
// - control bit 5 gates both match outputs
// - control bit 2 clears count on match
// - no clear on match when match zero
// - bit 7 resets block, releases two cycles later
// - bit 6 enables count, first after 64
// - disable stops prescaler, keeps count
// - load counter only while counting disabled
// - bit 1 low holds count at zero
// - bits 4:3 drive oscillator mode output
// - bit 0 drives oscillator select output
// - select low before sleep, high before standby
// - registers reached bytewise via config mux
package rtc_pkg;

    localparam int CNT_W      = 40;
    localparam int CNT_BYTES  = 5;
    localparam int CADDR_W    = 8;
    localparam int PRESC_W    = 7;

    // config mux byte addresses, five bytes per 40-bit quantity
    localparam logic [7:0] CADDR_COUNT = 8'h00;
    localparam logic [7:0] CADDR_MATCH = 8'h08;
    localparam logic [7:0] CADDR_MBITS = 8'h10;
    localparam logic [7:0] CADDR_CTRL  = 8'h18;

    // control_status fields
    localparam int CTRL_OSC_SEL   = 0;
    localparam int CTRL_CNT_RSTB  = 1;
    localparam int CTRL_CLR_OMAT  = 2;
    localparam int CTRL_MODE_LO   = 3;
    localparam int CTRL_MODE_HI   = 4;
    localparam int CTRL_MATCH_EN  = 5;
    localparam int CTRL_CNT_EN    = 6;
    localparam int CTRL_BLK_RST   = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // prescaler: divide by 128, first tick after 64 edges
    localparam logic [6:0] PRESC_START = 7'h40;
    localparam logic [6:0] PRESC_LAST  = 7'h7f;
    localparam logic [1:0] RST_DLY_LOAD = 2'h3;

    // host Avalon map: config byte n at byte address 4*n, status above
    localparam int AV_ADDR_W = 12;
    localparam logic [11:0] AV_STATUS = 12'h400;
    localparam int AV_STAT_MATCH = 0;
    localparam int AV_STAT_PSM   = 1;
    localparam int AV_STAT_SEL   = 2;
    localparam int AV_STAT_MODE  = 3;

    typedef enum logic [4:0] {
        RTC_H_IDLE = 5'b00001,
        RTC_H_WR   = 5'b00010,
        RTC_H_RD   = 5'b00100,
        RTC_H_WAIT = 5'b01000,
        RTC_H_DONE = 5'b10000
    } rtc_host_state_t;

endpackage

/* pkg/rtc_cfg_if.sv */
// Purpose: config mux byte link plus match and oscillator lines
// Assumes: both ends on clk_in
// Notes: timebase_clock is a raw pin level, the device resynchronises it
`timescale 1ns/10ps
`default_nettype none
interface rtc_cfg_if;
    logic       timebase_clock;
    logic [7:0] cfg_addr;
    logic [7:0] cfg_wdata;
    logic       cfg_wr;
    logic       cfg_rd;
    logic [7:0] cfg_rdata;
    logic       match_flag;
    logic       match_to_power_sequencer;
    logic [1:0] osc_mode;
    logic       osc_select;

    modport dev (
        input  timebase_clock, cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        output cfg_rdata, match_flag, match_to_power_sequencer, osc_mode, osc_select
    );
    modport host (
        output timebase_clock, cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
        input  cfg_rdata, match_flag, match_to_power_sequencer, osc_mode, osc_select
    );
endinterface
`default_nettype wire

/* verilog/rtc_device.sv */
// Purpose: 40-bit real-time match counter behind the config mux byte port
// Assumes: timebase is asynchronous and much slower than clk_in
// Notes: read data appears one cycle after cfg_rd
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rtc_device (
    input  wire logic  clk_in,
    input  wire logic  reset_in,
    rtc_cfg_if.dev     link,
    output logic       counting_out,
    output logic       block_reset_out
);
    import rtc_pkg::*;

    typedef struct packed {
        // timebase resync and edge detect
        logic [1:0]       tb_sync;
        logic             tb_prev;
        // prescaler
        logic [6:0]       presc;
        // counter, match value and read-hold copy
        logic [39:0]      count;
        logic [39:0]      match;
        logic [39:0]      hold;
        // control byte and block reset tail
        logic [7:0]       ctrl;
        logic [1:0]       rst_dly;
        // registered read byte
        logic [7:0]       rdata;
    } rtc_dev_st_t;

    // current and next state
    rtc_dev_st_t r;
    rtc_dev_st_t n;

    // byte index of addr within a five-byte field, or 7 when outside
    function automatic logic [2:0] byte_idx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] off;
        logic       in_range;
        off      = addr - base;
        in_range = (addr >= base) && (off < 8'(CNT_BYTES));
        if (in_range) begin
            byte_idx = off[2:0];
        end else begin
            byte_idx = 3'h7;
        end
    endfunction

    // true when a byte index landed inside its field
    function automatic logic in_field(input logic [2:0] idx);
        in_field = (idx != 3'h7);
    endfunction

    // one byte out of a 40-bit value, byte 0 lowest
    function automatic logic [7:0] get_byte(input logic [39:0] v, input logic [2:0] i);
        get_byte = v[{i, 3'h0} +: 8];
    endfunction

    // one byte replaced, the other four kept
    function automatic logic [39:0] put_byte(input logic [39:0] v, input logic [2:0] i,
                                             input logic [7:0] b);
        logic [39:0] t;
        t = v;
        t[{i, 3'h0} +: 8] = b;
        put_byte = t;
    endfunction

    // decode results shared by next-state and output logic
    logic       blk_rst;
    logic       counting;
    logic       equal;
    logic       tb_edge;
    logic       tick;
    logic       match_hit;
    logic       cnt_clear;
    logic       clr_on_match;
    logic       load_ok;
    logic [2:0] i_cnt;
    logic [2:0] i_mat;
    logic [2:0] i_mb;

    // decode and next-state
    always_comb begin
        n        = r;
        blk_rst  = r.ctrl[CTRL_BLK_RST] | (r.rst_dly != 2'h0);
        counting = r.ctrl[CTRL_CNT_EN] & ~blk_rst;
        equal    = (r.count == r.match);
        tb_edge  = r.tb_sync[1] & ~r.tb_prev;
        tick     = counting & tb_edge & (r.presc == PRESC_LAST);
        // field decodes of the shared byte address
        i_cnt    = byte_idx(link.cfg_addr, CADDR_COUNT);
        i_mat    = byte_idx(link.cfg_addr, CADDR_MATCH);
        i_mb     = byte_idx(link.cfg_addr, CADDR_MBITS);

        // two-flop resync of the raw timebase pin
        n.tb_sync = {r.tb_sync[0], link.timebase_clock};
        n.tb_prev = r.tb_sync[1];

        // block reset release stretched by two cycles
        if (r.ctrl[CTRL_BLK_RST]) begin
            n.rst_dly = RST_DLY_LOAD;
        end else begin
            n.rst_dly = {1'b0, r.rst_dly[1]};
        end

        // prescaler parks half way so the first tick needs 64 edges
        if (!counting) begin
            // stopping reloads the half-way point, the count is kept
            n.presc = PRESC_START;
        end else if (tb_edge) begin
            // wraps from 127 to 0, so later ticks are 128 edges apart
            n.presc = r.presc + 7'h01;
        end

        // one gated term drives both match outputs; low in block reset
        match_hit    = equal & r.ctrl[CTRL_MATCH_EN] & ~blk_rst;
        // block reset and the active-low clear bit both zero the count
        cnt_clear    = blk_rst | ~r.ctrl[CTRL_CNT_RSTB];
        // clear on match is off while the match value is all zero
        clr_on_match = r.ctrl[CTRL_CLR_OMAT] & equal & (r.match != '0);
        // loads while counting would race the increment, so drop them
        load_ok      = ~r.ctrl[CTRL_CNT_EN] & r.ctrl[CTRL_CNT_RSTB] & ~blk_rst;

        // counter: clear, clear-on-match, increment
        if (cnt_clear) begin
            n.count = '0;
        end else if (tick) begin
            if (clr_on_match) begin
                n.count = '0;
            end else begin
                n.count = r.count + 40'h1;
            end
        end

        // block reset wipes the stored values
        if (blk_rst) begin
            n.match = '0;
            n.hold  = '0;
        end

        // byte writes; control stays writable so reset can be lifted
        if (link.cfg_wr) begin
            if (link.cfg_addr == CADDR_CTRL) begin
                n.ctrl = link.cfg_wdata;
            end else if (!blk_rst) begin
                // count bytes only while stopped and not held clear
                if (in_field(i_cnt) && load_ok) begin
                    n.count = put_byte(r.count, i_cnt, link.cfg_wdata);
                end
                // match bytes may change at any time outside block reset
                if (in_field(i_mat)) begin
                    n.match = put_byte(r.match, i_mat, link.cfg_wdata);
                end
            end
        end

        // byte reads, registered one cycle
        if (link.cfg_rd) begin
            if (i_cnt == 3'h0) begin
                // byte 0 snapshots the count so bytes 1..4 stay coherent
                n.hold  = r.count;
                n.rdata = r.count[7:0];
            end else if (in_field(i_cnt)) begin
                n.rdata = get_byte(r.hold, i_cnt);
            end else if (in_field(i_mat)) begin
                n.rdata = get_byte(r.match, i_mat);
            end else if (in_field(i_mb)) begin
                // every match bits byte reads all ones on equality
                n.rdata = equal ? 8'hff : 8'h00;
            end else if (link.cfg_addr == CADDR_CTRL) begin
                n.rdata = r.ctrl;
            end else begin
                // unmapped bytes read as zero
                n.rdata = 8'h00;
            end
        end
    end

    // state register
    // reset names each field, otherwise the whole next copy is taken
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            r.tb_sync <= 2'h0;
            r.tb_prev <= 1'b0;
            r.presc   <= PRESC_START;
            r.count   <= '0;
            r.match   <= '0;
            r.hold    <= '0;
            r.ctrl    <= CTRL_RESET;
            r.rst_dly <= 2'h0;
            r.rdata   <= 8'h00;
        end else begin
            r <= n;
        end
    end

    // outputs follow registered state only
    assign link.cfg_rdata   = r.rdata;
    // one gated match term feeds both outputs, so they never disagree
    assign link.match_flag  = match_hit;
    assign link.match_to_power_sequencer = match_hit;
    // oscillator lines come straight from the control byte
    assign link.osc_mode    = r.ctrl[CTRL_MODE_HI:CTRL_MODE_LO];
    assign link.osc_select  = r.ctrl[CTRL_OSC_SEL];
    // status for the host side
    assign counting_out     = counting;
    assign block_reset_out  = blk_rst;

endmodule
`default_nettype wire

/* verilog/rtc_host.sv */
// Purpose: Avalon-MM slave that turns word accesses into config mux byte cycles
// Assumes: one request at a time, master holds it until waitrequest low
// Notes: software must respect counter load and oscillator select sequencing
`timescale 1ns/10ps
`default_nettype none
module rtc_host (
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic [rtc_pkg::AV_ADDR_W-1:0] avs_address_in,
    input  wire logic                    avs_read_in,
    input  wire logic                    avs_write_in,
    input  wire logic [31:0]             avs_writedata_in,
    output logic      [31:0]             avs_readdata_out,
    output logic                         avs_waitrequest_out,
    input  wire logic                    xtal_clkout_in,
    output logic                         match_flag_out,
    output logic                         match_to_power_sequencer_out,
    output logic      [1:0]              osc_mode_out,
    output logic                         osc_select_out,
    rtc_cfg_if.host                      link
);
    import rtc_pkg::*;

    typedef struct packed {
        rtc_host_state_t st;
        logic [7:0]      addr;
        logic [7:0]      wdata;
        logic [31:0]     rdata;
    } rtc_host_st_t;

    rtc_host_st_t r;
    rtc_host_st_t n;
    logic         in_cfg;

    // request sequencing
    always_comb begin
        n      = r;
        in_cfg = (avs_address_in < AV_STATUS);
        case (r.st)
            RTC_H_IDLE: begin
                n.addr  = avs_address_in[9:2];
                n.wdata = avs_writedata_in[7:0];
                if (avs_write_in) begin
                    n.st = in_cfg ? RTC_H_WR : RTC_H_DONE;
                end else if (avs_read_in) begin
                    n.rdata = '0;
                    if (in_cfg) begin
                        n.st = RTC_H_RD;
                    end else begin
                        n.st = RTC_H_DONE;
                        if (avs_address_in == AV_STATUS) begin
                            n.rdata[AV_STAT_MATCH] = link.match_flag;
                            n.rdata[AV_STAT_PSM]   = link.match_to_power_sequencer;
                            n.rdata[AV_STAT_SEL]   = link.osc_select;
                            n.rdata[AV_STAT_MODE +: 2] = link.osc_mode;
                        end
                    end
                end
            end
            RTC_H_WR:   n.st = RTC_H_DONE;
            RTC_H_RD:   n.st = RTC_H_WAIT;
            RTC_H_WAIT: begin
                n.rdata = {24'h000000, link.cfg_rdata};              // narrow data in low bits
                n.st    = RTC_H_DONE;
            end
            RTC_H_DONE: n.st = RTC_H_IDLE;
            default:    n.st = RTC_H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            r.st    <= RTC_H_IDLE;
            r.addr  <= 8'h00;
            r.wdata <= 8'h00;
            r.rdata <= 32'h00000000;
        end else begin
            r <= n;
        end
    end

    // the timebase must be the crystal oscillator output, nothing else
    assign link.timebase_clock = xtal_clkout_in;
    assign link.cfg_addr       = r.addr;
    assign link.cfg_wdata      = r.wdata;
    assign link.cfg_wr         = (r.st == RTC_H_WR);
    assign link.cfg_rd         = (r.st == RTC_H_RD);
    assign avs_readdata_out    = r.rdata;
    assign avs_waitrequest_out = (r.st != RTC_H_DONE);
    assign match_flag_out      = link.match_flag;
    assign match_to_power_sequencer_out = link.match_to_power_sequencer;
    assign osc_mode_out        = link.osc_mode;
    assign osc_select_out      = link.osc_select;

endmodule
`default_nettype wire

/* dv/rtc_cfg_monitor.sv */
// Purpose: checks on the config link between host bridge and counter
// Assumes: one clock, synchronous active-high reset
// Notes: mirrors the control byte from the writes it sees
`timescale 1ns/10ps
`default_nettype none
module rtc_cfg_monitor (
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic       cfg_wr,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_rdata,
    input wire logic       match_flag,
    input wire logic       match_to_power_sequencer,
    input wire logic [1:0] osc_mode,
    input wire logic       osc_select
);
    import rtc_pkg::*;
    logic [7:0] ctrl_r;
    logic [2:0] quiet_r;
    logic [2:0] blk_r;
    // settle counters: match outputs may move just after writes or block reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r  <= 8'h00;
            quiet_r <= 3'h0;
            blk_r   <= 3'h0;
        end else begin
            if (cfg_wr && cfg_addr == CADDR_CTRL)
                ctrl_r <= cfg_wdata;
            quiet_r <= cfg_wr ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
            blk_r   <= ctrl_r[7] ? 3'h0 : blk_r + {2'h0, blk_r != 3'h7};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_mbits_rd;
        cfg_rd && cfg_addr >= CADDR_MBITS && cfg_addr < CADDR_MBITS + 8'h05
            && ctrl_r[5] && blk_r > 3'h4;
    endsequence
    sequence s_ctrl_rd;
        cfg_rd && cfg_addr == CADDR_CTRL;
    endsequence
    mode_field_a: assert property (osc_mode == ctrl_r[4:3])
        else $error("oscillator mode differs from control byte");
    select_bit_a: assert property (osc_select == ctrl_r[0])
        else $error("oscillator select differs from control byte");
    match_gate_a: assert property (
        !ctrl_r[5] |-> !match_flag && !match_to_power_sequencer)
        else $error("match output high while gated off");
    match_pair_a: assert property (match_flag == match_to_power_sequencer)
        else $error("match outputs disagree");
    ctrl_read_a: assert property (s_ctrl_rd |=> cfg_rdata == ctrl_r)
        else $error("control byte read back wrong");
    match_bits_a: assert property (s_mbits_rd |=> cfg_rdata == {8{$past(match_flag)}})
        else $error("match bits disagree with match output");
    count_clear_a: assert property (
        cfg_rd && cfg_addr == CADDR_COUNT && !ctrl_r[1] && quiet_r > 3'h2 |=> cfg_rdata == 8'h00)
        else $error("count not zero while held clear");
    idle_hold_a: assert property (
        quiet_r > 3'h4 && blk_r > 3'h4 && !ctrl_r[6] |-> $stable(match_flag))
        else $error("match moved while counting is off");
    strobe_pulse_a: assert property (cfg_wr |-> !cfg_rd ##1 !cfg_wr)
        else $error("write strobe not a single lone pulse");
endmodule
`default_nettype wire

/* dv/rtc_match_counter_bench.sv */
// Purpose: drives the bridge over Avalon and checks the counter end to end
// Assumes: crystal clock made here at a quarter of clk_in
// Notes: read data is checked by a watcher against queued notes
`timescale 1ns/10ps
`default_nettype none
module rtc_match_counter_bench;
    import rtc_pkg::*;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [11:0] av_addr = 12'h000;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic        av_wait, xtal = 1'b0, match_out, psm_out, sel_out, counting, blk_rst;
    logic [1:0]  div_r = 2'h0, mode_out;
    logic [15:0] seed = 16'h65d2;
    logic [31:0] exp_q[$];
    int          mismatches = 0;
    int          total_checks = 0;
    rtc_cfg_if link ();
    rtc_host i_rtc_host (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
        .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .xtal_clkout_in(xtal),
        .match_flag_out(match_out), .match_to_power_sequencer_out(psm_out),
        .osc_mode_out(mode_out), .osc_select_out(sel_out), .link(link));
    rtc_device i_rtc_device (.clk_in(clk_in), .reset_in(reset_in), .link(link),
        .counting_out(counting), .block_reset_out(blk_rst));
    rtc_cfg_monitor i_rtc_cfg_monitor (.clk_in(clk_in), .reset_in(reset_in),
        .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_wr(link.cfg_wr),
        .cfg_rd(link.cfg_rd), .cfg_rdata(link.cfg_rdata), .match_flag(link.match_flag),
        .match_to_power_sequencer(link.match_to_power_sequencer),
        .osc_mode(link.osc_mode), .osc_select(link.osc_select));
    // clock; crystal at a quarter rate so the synchroniser sees every edge
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        div_r <= div_r + 2'h1;
        xtal  <= div_r[1];
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [11:0] ba(input logic [7:0] n);
        return {2'b00, n, 2'b00};
    endfunction
    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one Avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        av_addr  <= a;
        av_wr    <= wr;
        av_rd    <= !wr;
        av_wdata <= {24'h0, d};
        // no cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge clk_in);
        end while (av_wait !== 1'b0);
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic wr8(input logic [7:0] n, input logic [7:0] d);
        bus(1'b1, ba(n), d);
    endtask
    task automatic rd8(input logic [11:0] a, input logic [7:0] want);
        exp_q.push_back({24'h0, want});
        bus(1'b0, a, 8'h00);
    endtask
    // low byte at the lowest address; count byte 0 first so the hold copy is taken
    task automatic wr40(input logic [7:0] base, input logic [39:0] v);
        for (int i = 0; i < CNT_BYTES; i++)
            wr8(base + 8'(i), v[8*i +: 8]);
    endtask
    task automatic rd40(input logic [7:0] base, input logic [39:0] v);
        for (int i = 0; i < CNT_BYTES; i++)
            rd8(ba(base + 8'(i)), v[8*i +: 8]);
    endtask
    // watcher: read data taken at the completing edge
    always @(posedge clk_in) begin
        if (av_rd && av_wait === 1'b0 && exp_q.size() > 0)
            check({8'h00, av_rdata}, {8'h00, exp_q.pop_front()});
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        end_of_test();
    end
    initial begin
        logic [39:0] v;
        int          t;
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        rd8(ba(CADDR_CTRL), CTRL_RESET);
        bus(1'b1, 12'h404, 8'h5a);
        rd8(12'h404, 8'h00);
        // every mode and select value reaches the oscillator lines
        for (int m = 0; m < 8; m++) begin
            wr8(CADDR_CTRL, {3'h0, m[2:1], 2'b01, m[0]});
            check({38'h0, mode_out}, {38'h0, m[2:1]});
            check({39'h0, sel_out}, {39'h0, m[0]});
            rd8(AV_STATUS, {3'h0, m[2:1], m[0], 2'b00});
        end
        seed = lfsr(seed);
        v = {seed, lfsr(seed), seed[7:0]};
        wr40(CADDR_COUNT, v);
        rd40(CADDR_COUNT, v);
        wr40(CADDR_MATCH, v + 40'h2);
        rd40(CADDR_MATCH, v + 40'h2);
        wr8(CADDR_CTRL, 8'h26);
        rd40(CADDR_MBITS, 40'h0);
        // two increments then clear on match
        wr8(CADDR_CTRL, 8'h66);
        for (t = 0; t < 1000 && match_out !== 1'b1; t++)
            @(posedge clk_in);
        check({39'h0, t >= 760 && t <= 790}, 40'h1);
        check({38'h0, psm_out, counting}, 40'h3);
        rd8(ba(CADDR_MBITS), 8'hff);
        repeat (600) @(posedge clk_in);
        wr8(CADDR_CTRL, 8'h26);
        rd40(CADDR_COUNT, 40'h0);
        // zero match must not clear; loads while counting are dropped
        wr40(CADDR_MATCH, 40'h0);
        wr40(CADDR_COUNT, 40'h0);
        wr8(CADDR_CTRL, 8'h46);
        check({39'h0, match_out}, 40'h0);
        wr8(CADDR_COUNT, seed[7:0] | 8'h80);
        repeat (400) @(posedge clk_in);
        wr8(CADDR_CTRL, 8'h06);
        repeat (600) @(posedge clk_in);
        rd40(CADDR_COUNT, 40'h1);
        wr40(CADDR_COUNT, v);
        wr8(CADDR_CTRL, 8'h00);
        rd40(CADDR_COUNT, 40'h0);
        // block reset wipes match, refuses data writes, releases two cycles late
        wr8(CADDR_MATCH, 8'h5a);
        rd8(ba(CADDR_MATCH), 8'h5a);
        wr8(CADDR_CTRL, 8'h82);
        check({39'h0, blk_rst}, 40'h1);
        wr8(CADDR_MATCH, 8'h33);
        wr8(CADDR_CTRL, 8'h02);
        @(posedge clk_in);
        check({39'h0, blk_rst}, 40'h1);
        @(posedge clk_in);
        check({39'h0, blk_rst}, 40'h0);
        rd8(ba(CADDR_MATCH), 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
